// *** mcu16_decode_regs.svh ***
// Register offsets, field positions, reset values, opcodes and cycle counts of the instruction decoder.
`ifndef MCU16_DECODE_REGS_SVH
`define MCU16_DECODE_REGS_SVH

`define REG_CTRL        4'h0
`define REG_FLAGS       4'h4
`define REG_STATE       4'h8
`define REG_COUNT       4'hC

`define CTRL_ENABLE_BIT 0
`define CTRL_CLRERR_BIT 1
`define CTRL_ENABLE_RST 1'b1
`define FLAGS_RST       5'h00
`define FLAG_C          0
`define FLAG_DC         1
`define FLAG_N          2
`define FLAG_OV         3
`define FLAG_Z          4
`define STATE_ERR_BIT   4

`define OPC_NOP         8'h00
`define OPC_BRA_COMP    8'h01
`define OPC_CALL_ABS    8'h02
`define OPC_ABSOLUTE_JUMP_ABS    8'h04
`define OPC_JUMP_IND    8'h05
`define OPC_RETURN      8'h06
`define OPC_INT_EXIT    8'h07
`define OPC_BRA_COND    8'h31
`define OPC_BRA_UNC     8'h37
`define OPC_MOV         8'h78
`define OPC_MOV_EXT     8'h79
`define OPC_SKIP        8'hA6
`define OPC_FILE        8'hB4
`define OPC_SQR         8'hB9
`define OPC_TBL         8'hBA
`define OPC_DIV         8'hD8

`define FILE_DEST_BIT   13
`define SQR_BASE        2'h1

`define LSEL_1          3'h0
`define LSEL_4          3'h1
`define LSEL_5          3'h2
`define LSEL_8          3'h3
`define LSEL_10         3'h4
`define LSEL_14         3'h5
`define LSEL_16         3'h6
`define LSEL_S6         3'h7

`define CYC_ONE         2'h1
`define CYC_TWO         2'h2
`define CYC_THREE       2'h3

`endif

// *** mcu16_decode_pkg.sv ***
// Types shared by the instruction decoder: states, operand modes, size qualifiers and the state record.
package mcu16_decode_pkg;

    typedef enum logic [1:0] {
        S_FETCH  = 2'h0,
        S_SECOND = 2'h1,
        S_EXTRA  = 2'h3
    } state_e;

    typedef enum logic [2:0] {
        M_DIRECT  = 3'h0,
        M_IND     = 3'h1,
        M_POSTINC = 3'h2,
        M_POSTDEC = 3'h3,
        M_PREINC  = 3'h4,
        M_PREDEC  = 3'h5,
        M_OFFSET  = 3'h6
    } mode_e;

    typedef enum logic [1:0] {
        SZ_WORD   = 2'h0,
        SZ_BYTE   = 2'h1,
        SZ_DOUBLE = 2'h2,
        SZ_SHADOW = 2'h3
    } size_e;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [3:0]  source_operand;
        logic [2:0]  src_mode;
        logic [3:0]  dest_operand;
        logic [2:0]  dst_mode;
        logic [3:0]  base_work_reg;
        logic [1:0]  size;
        logic        shadow;
        logic [3:0]  bit_index_field;
        logic [12:0] file_addr;
        logic [15:0] lit_uns;
        logic [15:0] lit_sig;
        logic [3:0]  dividend_or_square_reg;
        logic        form_err;
    } dec_s;

    typedef struct packed {
        state_e      state;
        logic        waitreq;
        logic [31:0] rdata;
        logic        enable;
        logic [4:0]  flags;
        logic        err;
        logic [15:0] count;
        logic [23:0] word1;
        logic [1:0]  extra;
        logic        ready;
        logic        exec_valid;
        logic        nop_slot;
        logic [1:0]  cycles;
        logic [22:0] program_address_literal;
        dec_s        dec;
    } state_s;

endpackage

// *** mcu16_instr_timing_operands.sv ***
// Instruction word decoder: cycle timing, operand field extraction, status flags and register slave.
`timescale 1ns/1ps
`include "mcu16_decode_regs.svh"

// How it works
// - Each word is 24 bits; the top eight bits are the opcode.
// - Second word of a two-word instruction must have its top eight bits zero.
// - A second word executed on its own behaves as a no-operation.
// - Single-word takes one cycle; two when condition true or program counter changes.
// - Unconditional and computed branches, indirect jumps and table accesses take two cycles; returns take three.
// - A performed skip takes two cycles, three when the skipped instruction is double-word.
// - Double-word moves take two cycles.
// - Every two-word instruction executes in two cycles.
// - Bit index is a four-bit field selecting bit 0 to 15.
// - Status holds carry, digit carry, negative, overflow and sticky zero flags.
// - File-register operand addresses data 0 to 0x1FFF.
// - Unsigned literals are zero-extended from 1, 4, 5, 8, 14 or 16 bits.
// - Ten-bit unsigned literal limited to 0..255 in byte mode, 0..1023 otherwise.
// - Program address literal is 23 bits with its lowest bit zero.
// - Signed literals of 6, 10 and 16 bits are sign-extended.
// - Register fields pick one of sixteen working registers.
// - File-register instructions default their alternate destination to register zero.
// - Square operands come only from working registers four to seven.
// - Divide operands use direct register addressing only.
// - Extended operand forms add register-plus-base indirect addressing.
// - Size qualifier picks byte, word or double word; word default; shadow separate.
module mcu16_instr_timing_operands (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic [23:0] INSTR_WORD,
    input  wire logic        INSTR_VALID,
    output logic             INSTR_READY,
    input  wire logic        COND_TRUE,
    input  wire logic        SKIP_NEXT_TWO,
    input  wire logic [2:0]  LIT_SEL,
    input  wire logic [4:0]  FLAG_WE,
    input  wire logic [4:0]  FLAG_VAL,
    input  wire logic        Z_STICKY,
    output logic             EXEC_VALID,
    output logic             NOP_SLOT,
    output logic      [1:0]  EXEC_CYCLES,
    output logic      [7:0]  OPCODE,
    output logic      [3:0]  SOURCE_OPERAND,
    output logic      [2:0]  SRC_MODE,
    output logic      [3:0]  DEST_OPERAND,
    output logic      [2:0]  DST_MODE,
    output logic      [3:0]  BASE_WORK_REG,
    output logic      [1:0]  SIZE,
    output logic             SHADOW,
    output logic      [3:0]  BIT_INDEX_FIELD,
    output logic      [12:0] FILE_ADDR,
    output logic      [15:0] LIT_UNS,
    output logic      [15:0] LIT_SIG,
    output logic      [22:0] PROGRAM_ADDRESS_LITERAL,
    output logic      [3:0]  DIVIDEND_OR_SQUARE_REG,
    output logic             FORM_ERR,
    output logic      [4:0]  FLAGS
);

    mcu16_decode_pkg::state_s st;
    mcu16_decode_pkg::state_s next_st;
    logic                     req;
    logic                     take;
    logic [7:0]               in_opc;

    function automatic mcu16_decode_pkg::dec_s decode(input logic [23:0] w, input logic [2:0] sel);
        mcu16_decode_pkg::dec_s d;
        logic                   ext;
        d = '0;
        d.opcode = w[23:16];
        d.source_operand = w[3:0];
        d.src_mode = w[6:4];
        d.dest_operand = w[10:7];
        d.dst_mode = w[13:11];
        d.base_work_reg = w[15:12];
        d.size = w[15:14];
        d.shadow = (w[15:14] == mcu16_decode_pkg::SZ_SHADOW);
        if (d.shadow) begin
            d.size = mcu16_decode_pkg::SZ_WORD;
        end
        d.bit_index_field = w[15:12];
        d.file_addr = w[12:0];
        if (d.opcode == `OPC_FILE && !w[`FILE_DEST_BIT]) begin
            d.dest_operand = 4'h0;
        end
        case (sel)
            `LSEL_1:  d.lit_uns = {15'h0000, w[0]};
            `LSEL_4:  d.lit_uns = {12'h000, w[3:0]};
            `LSEL_5:  d.lit_uns = {11'h000, w[4:0]};
            `LSEL_8:  d.lit_uns = {8'h00, w[7:0]};
            `LSEL_10: d.lit_uns = (d.size == mcu16_decode_pkg::SZ_BYTE) ? {8'h00, w[11:4]} : {6'h00, w[13:4]};
            `LSEL_14: d.lit_uns = {2'h0, w[13:0]};
            default:  d.lit_uns = w[15:0];
        endcase
        case (sel)
            `LSEL_S6: d.lit_sig = {{10{w[5]}}, w[5:0]};
            `LSEL_10: d.lit_sig = {{6{w[13]}}, w[13:4]};
            default:  d.lit_sig = w[15:0];
        endcase
        if (d.opcode == `OPC_SQR) begin
            d.dividend_or_square_reg = {`SQR_BASE, w[1:0]};
        end else begin
            d.dividend_or_square_reg = w[3:0];
        end
        ext = (d.opcode == `OPC_MOV_EXT);
        // Offset mode is only legal in the extended forms, and codes above it are unused.
        d.form_err = (!ext && (d.src_mode == mcu16_decode_pkg::M_OFFSET || d.dst_mode == mcu16_decode_pkg::M_OFFSET))
                   || (&d.src_mode) || (&d.dst_mode);
        if (d.opcode == `OPC_DIV && (d.src_mode != mcu16_decode_pkg::M_DIRECT
                                     || d.dst_mode != mcu16_decode_pkg::M_DIRECT)) begin
            d.form_err = 1'b1;
        end
        return d;
    endfunction

    function automatic logic [1:0] cycles_of(input logic [23:0] w, input logic cond, input logic two_next);
        logic [1:0] c;
        c = `CYC_ONE;
        case (w[23:16])
            `OPC_NOP:      c = `CYC_ONE;
            `OPC_BRA_COND: c = cond ? `CYC_TWO : `CYC_ONE;
            `OPC_BRA_UNC,
            `OPC_BRA_COMP,
            `OPC_JUMP_IND,
            `OPC_TBL:      c = `CYC_TWO;
            `OPC_RETURN,
            `OPC_INT_EXIT: c = `CYC_THREE;
            `OPC_SKIP:     c = !cond ? `CYC_ONE : (two_next ? `CYC_THREE : `CYC_TWO);
            `OPC_MOV,
            `OPC_MOV_EXT:  c = (w[15:14] == mcu16_decode_pkg::SZ_DOUBLE) ? `CYC_TWO : `CYC_ONE;
            default:       c = `CYC_ONE;
        endcase
        return c;
    endfunction

    assign req = AVS_READ || AVS_WRITE;
    assign take = INSTR_VALID && st.ready;
    assign in_opc = INSTR_WORD[23:16];

    always_comb begin
        next_st = st;
        next_st.exec_valid = 1'b0;
        // Bus answer: waitrequest drops one cycle after a request appears, for exactly one cycle.
        next_st.waitreq = !(req && st.waitreq);
        if (req && st.waitreq) begin
            case (AVS_ADDRESS)
                `REG_CTRL:  next_st.rdata = {31'h00000000, st.enable};
                `REG_FLAGS: next_st.rdata = {27'h0000000, st.flags};
                `REG_STATE: next_st.rdata = {27'h0000000, st.err, st.state, st.cycles};
                `REG_COUNT: next_st.rdata = {16'h0000, st.count};
                default:    next_st.rdata = 32'h00000000;
            endcase
        end
        if (AVS_WRITE && !st.waitreq) begin
            case (AVS_ADDRESS)
                `REG_CTRL: begin
                    next_st.enable = AVS_WRITEDATA[`CTRL_ENABLE_BIT];
                    if (AVS_WRITEDATA[`CTRL_CLRERR_BIT]) begin
                        next_st.err = 1'b0;
                    end
                end
                `REG_FLAGS: next_st.flags = AVS_WRITEDATA[4:0];
                default: next_st.flags = next_st.flags;
            endcase
        end
        // Hardware flag updates land after a software write so the core's own result is never lost.
        for (int i = 0; i < 5; i++) begin
            if (FLAG_WE[i]) begin
                next_st.flags[i] = FLAG_VAL[i];
            end
        end
        if (FLAG_WE[`FLAG_Z] && Z_STICKY) begin
            next_st.flags[`FLAG_Z] = st.flags[`FLAG_Z] & FLAG_VAL[`FLAG_Z];
        end
        case (st.state)
            mcu16_decode_pkg::S_FETCH: begin
                if (take) begin
                    if (in_opc == `OPC_ABSOLUTE_JUMP_ABS || in_opc == `OPC_CALL_ABS) begin
                        next_st.word1 = INSTR_WORD;
                        next_st.state = mcu16_decode_pkg::S_SECOND;
                    end else begin
                        next_st.dec = decode(INSTR_WORD, LIT_SEL);
                        next_st.cycles = cycles_of(INSTR_WORD, COND_TRUE, SKIP_NEXT_TWO);
                        next_st.program_address_literal = 23'h000000;
                        next_st.exec_valid = 1'b1;
                        if (next_st.cycles != `CYC_ONE) begin
                            // Extra cycles after the first are issued as no-operation slots.
                            next_st.extra = next_st.cycles - `CYC_ONE;
                            next_st.state = mcu16_decode_pkg::S_EXTRA;
                        end
                    end
                end
            end
            mcu16_decode_pkg::S_SECOND: begin
                if (take) begin
                    next_st.dec = decode(st.word1, LIT_SEL);
                    next_st.program_address_literal = {INSTR_WORD[6:0], st.word1[15:1], 1'b0};
                    next_st.cycles = `CYC_TWO;
                    next_st.exec_valid = 1'b1;
                    if (in_opc != 8'h00) begin
                        next_st.err = 1'b1;
                    end
                    next_st.state = mcu16_decode_pkg::S_FETCH;
                end
            end
            mcu16_decode_pkg::S_EXTRA: begin
                next_st.extra = st.extra - 2'h1;
                if (st.extra == 2'h1) begin
                    next_st.state = mcu16_decode_pkg::S_FETCH;
                end
            end
            default: next_st.state = mcu16_decode_pkg::S_FETCH;
        endcase
        if (next_st.exec_valid) begin
            next_st.count = st.count + 16'h0001;
        end
        next_st.nop_slot = (next_st.state == mcu16_decode_pkg::S_EXTRA);
        // A disabled decoder still accepts a pending second word so no instruction is split.
        next_st.ready = (next_st.state == mcu16_decode_pkg::S_SECOND)
                      || (next_st.enable && next_st.state == mcu16_decode_pkg::S_FETCH);
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st         <= '0;
            st.state   <= mcu16_decode_pkg::S_FETCH;
            st.waitreq <= 1'b1;
            st.enable  <= `CTRL_ENABLE_RST;
            st.flags   <= `FLAGS_RST;
            st.ready   <= `CTRL_ENABLE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign AVS_READDATA            = st.rdata;
    assign AVS_WAITREQUEST         = st.waitreq;
    assign INSTR_READY             = st.ready;
    assign EXEC_VALID              = st.exec_valid;
    assign NOP_SLOT                = st.nop_slot;
    assign EXEC_CYCLES             = st.cycles;
    assign OPCODE                  = st.dec.opcode;
    assign SOURCE_OPERAND          = st.dec.source_operand;
    assign SRC_MODE                = st.dec.src_mode;
    assign DEST_OPERAND            = st.dec.dest_operand;
    assign DST_MODE                = st.dec.dst_mode;
    assign BASE_WORK_REG           = st.dec.base_work_reg;
    assign SIZE                    = st.dec.size;
    assign SHADOW                  = st.dec.shadow;
    assign BIT_INDEX_FIELD         = st.dec.bit_index_field;
    assign FILE_ADDR               = st.dec.file_addr;
    assign LIT_UNS                 = st.dec.lit_uns;
    assign LIT_SIG                 = st.dec.lit_sig;
    assign PROGRAM_ADDRESS_LITERAL = st.program_address_literal;
    assign DIVIDEND_OR_SQUARE_REG  = st.dec.dividend_or_square_reg;
    assign FORM_ERR                = st.dec.form_err;
    assign FLAGS                   = st.flags;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    a_second_word_check: assert property ((st.state == mcu16_decode_pkg::S_SECOND && take && in_opc != 8'h00)
        |=> st.err && EXEC_CYCLES == `CYC_TWO) else $error("nonzero second word not flagged");
    a_lone_second_nop: assert property ((st.state == mcu16_decode_pkg::S_FETCH && take && in_opc == `OPC_NOP)
        |=> EXEC_VALID && EXEC_CYCLES == `CYC_ONE && !NOP_SLOT) else $error("lone second word not a nop");
    a_cond_taken_slot: assert property ((st.state == mcu16_decode_pkg::S_FETCH && take
        && in_opc == `OPC_BRA_COND && COND_TRUE) |=> NOP_SLOT ##1 !NOP_SLOT) else $error("taken branch slot wrong");
    a_return_three: assert property ((st.state == mcu16_decode_pkg::S_FETCH && take && in_opc == `OPC_RETURN)
        |=> NOP_SLOT [*2] ##1 (!NOP_SLOT && INSTR_READY == st.enable)) else $error("return not three cycles");
    a_skip_over_double: assert property ((st.state == mcu16_decode_pkg::S_FETCH && take && in_opc == `OPC_SKIP
        && COND_TRUE && SKIP_NEXT_TWO) |=> EXEC_CYCLES == `CYC_THREE) else $error("skip over double wrong");
    a_double_move: assert property ((st.state == mcu16_decode_pkg::S_FETCH && take && in_opc == `OPC_MOV
        && INSTR_WORD[15:14] == mcu16_decode_pkg::SZ_DOUBLE) |=> EXEC_CYCLES == `CYC_TWO && NOP_SLOT)
        else $error("double move not two cycles");
    a_two_word_flow: assert property ((st.state == mcu16_decode_pkg::S_FETCH && take && in_opc == `OPC_ABSOLUTE_JUMP_ABS)
        |=> !EXEC_VALID && INSTR_READY) else $error("two-word first word mishandled");
    a_prog_addr_even: assert property ((st.state == mcu16_decode_pkg::S_SECOND && take)
        |=> EXEC_VALID && PROGRAM_ADDRESS_LITERAL[0] == 1'b0) else $error("program address odd");
    a_square_range: assert property ((EXEC_VALID && OPCODE == `OPC_SQR)
        |-> DIVIDEND_OR_SQUARE_REG >= 4'h4 && DIVIDEND_OR_SQUARE_REG <= 4'h7) else $error("square reg out of range");
    a_sticky_zero: assert property ((FLAG_WE[`FLAG_Z] && Z_STICKY && !FLAGS[`FLAG_Z])
        |=> !FLAGS[`FLAG_Z]) else $error("sticky zero was set");
    a_bus_answer: assert property ((req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer timing wrong");
    a_slot_not_ready: assert property (NOP_SLOT |-> !INSTR_READY) else $error("word accepted in filler slot");
    a_div_direct_only: assert property ((EXEC_VALID && OPCODE == `OPC_DIV && |{SRC_MODE, DST_MODE})
        |-> FORM_ERR) else $error("indirect divide not refused");

    c_two_word: cover property (st.state == mcu16_decode_pkg::S_SECOND && take);
    c_three_cycle: cover property (EXEC_VALID && EXEC_CYCLES == `CYC_THREE);
    c_bus_write: cover property (AVS_WRITE && !AVS_WAITREQUEST);
    c_skip_double: cover property (EXEC_VALID && OPCODE == `OPC_SKIP && EXEC_CYCLES == `CYC_THREE);
    c_form_refused: cover property (EXEC_VALID && FORM_ERR);

endmodule // mcu16_instr_timing_operands

// *** mcu16_fetch_model.sv ***
// Fetch-side partner model: offers one program word at a time on the valid/ready handshake.
`timescale 1ns/1ps
module mcu16_fetch_model (
    input  wire logic        clk,
    input  wire logic        instr_ready,
    output logic      [23:0] instr_word,
    output logic             instr_valid,
    output logic             cond_true,
    output logic             skip_next_two,
    output logic      [2:0]  lit_sel
);
    initial begin
        instr_word    = 24'h000000;
        instr_valid   = 1'h0;
        cond_true     = 1'h0;
        skip_next_two = 1'h0;
        lit_sel       = 3'h0;
    end

    // The word and its side bits are held until taken; afterwards the released lines show the inverse,
    // so the decoder cannot lean on a stale value.
    task automatic send(input logic [23:0] w, input logic c, input logic s, input logic [2:0] l, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        instr_word    <= w;
        instr_valid   <= 1'h1;
        cond_true     <= c;
        skip_next_two <= s;
        lit_sel       <= l;
        do begin
            @(posedge clk);
            n++;
        end while (instr_ready !== 1'h1 && n < 50);
        instr_valid   <= 1'h0;
        instr_word    <= ~w;
        cond_true     <= ~c;
        skip_next_two <= ~s;
        lit_sel       <= ~l;
        ok = (n < 50);
    endtask
endmodule // mcu16_fetch_model

// *** mcu16_instr_timing_operands_tb_top.sv ***
// Self-checking testbench of the instruction decoder: timing, operand fields, flags and registers.
`timescale 1ns/1ps
`include "mcu16_decode_regs.svh"
module mcu16_instr_timing_operands_tb_top;
    logic CORE_CLK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, INSTR_VALID, INSTR_READY, COND_TRUE;
    logic SKIP_NEXT_TWO, Z_STICKY, EXEC_VALID, NOP_SLOT, SHADOW, FORM_ERR;
    logic [3:0]  AVS_ADDRESS, SOURCE_OPERAND, DEST_OPERAND, BASE_WORK_REG, BIT_INDEX_FIELD, DIVIDEND_OR_SQUARE_REG;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
    logic [23:0] INSTR_WORD;
    logic [2:0]  LIT_SEL, SRC_MODE, DST_MODE;
    logic [4:0]  FLAG_WE, FLAG_VAL, FLAGS;
    logic [1:0]  EXEC_CYCLES, SIZE;
    logic [7:0]  OPCODE;
    logic [12:0] FILE_ADDR;
    logic [15:0] LIT_UNS, LIT_SIG;
    logic [22:0] PROGRAM_ADDRESS_LITERAL;
    logic        ok;
    int          errors = 0, n_checks = 0, nops, issued = 0;
    // Timing table: word, condition, skipped-is-double, expected total cycles.
    logic [23:0] tw [0:13] = '{{`OPC_NOP, 16'h0000}, {`OPC_BRA_COND, 16'h0000}, {`OPC_BRA_COND, 16'h0000},
        {`OPC_BRA_UNC, 16'h0000}, {`OPC_BRA_COMP, 16'h0000}, {`OPC_JUMP_IND, 16'h0000}, {`OPC_TBL, 16'h0000},
        {`OPC_RETURN, 16'h0000}, {`OPC_INT_EXIT, 16'h0000}, {`OPC_SKIP, 16'h0000}, {`OPC_SKIP, 16'h0000},
        {`OPC_SKIP, 16'h0000}, {`OPC_MOV, 16'h8000}, {`OPC_MOV, 16'h0000}};
    logic [13:0] tc = 14'h0C04;
    logic [13:0] ts = 14'h0800;
    logic [1:0]  te [0:13] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1};
    logic [15:0] lu [0:6] = '{16'h0001, 16'h000F, 16'h001F, 16'h00FF, 16'h03FF, 16'h3FFF, 16'hFFFF};

    mcu16_instr_timing_operands mcu16_instr_timing_operands_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .INSTR_WORD(INSTR_WORD),
        .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY), .COND_TRUE(COND_TRUE),
        .SKIP_NEXT_TWO(SKIP_NEXT_TWO), .LIT_SEL(LIT_SEL), .FLAG_WE(FLAG_WE), .FLAG_VAL(FLAG_VAL),
        .Z_STICKY(Z_STICKY), .EXEC_VALID(EXEC_VALID), .NOP_SLOT(NOP_SLOT), .EXEC_CYCLES(EXEC_CYCLES),
        .OPCODE(OPCODE), .SOURCE_OPERAND(SOURCE_OPERAND), .SRC_MODE(SRC_MODE), .DEST_OPERAND(DEST_OPERAND),
        .DST_MODE(DST_MODE), .BASE_WORK_REG(BASE_WORK_REG), .SIZE(SIZE), .SHADOW(SHADOW),
        .BIT_INDEX_FIELD(BIT_INDEX_FIELD), .FILE_ADDR(FILE_ADDR), .LIT_UNS(LIT_UNS), .LIT_SIG(LIT_SIG),
        .PROGRAM_ADDRESS_LITERAL(PROGRAM_ADDRESS_LITERAL), .DIVIDEND_OR_SQUARE_REG(DIVIDEND_OR_SQUARE_REG),
        .FORM_ERR(FORM_ERR), .FLAGS(FLAGS));
    mcu16_fetch_model mcu16_fetch_model_inst (.clk(CORE_CLK), .instr_ready(INSTR_READY), .instr_word(INSTR_WORD),
        .instr_valid(INSTR_VALID), .cond_true(COND_TRUE), .skip_next_two(SKIP_NEXT_TWO), .lit_sel(LIT_SEL));

    initial begin
        CORE_CLK = 1'h0;
        forever #2 CORE_CLK = ~CORE_CLK;
    end

    task automatic conclude();
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One Avalon transfer; the request is held until the edge that samples waitrequest low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE     <= wr;
        AVS_READ      <= ~wr;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'h0 && n < 20);
        if (n >= 20) begin
            errors++;
            conclude();
        end
        q = AVS_READDATA;
        AVS_READ  <= 1'h0;
        AVS_WRITE <= 1'h0;
    endtask

    // Issues one word, waits for the issue pulse, then counts the filler no-operation cycles.
    task automatic run(input logic [23:0] w, input logic c, input logic s, input logic [2:0] l);
        int n;
        mcu16_fetch_model_inst.send(w, c, s, l, ok);
        n = 0;
        do begin
            @(negedge CORE_CLK);
            n++;
        end while (EXEC_VALID !== 1'h1 && n < 20);
        if (ok !== 1'h1 || n >= 20) begin
            errors++;
            conclude();
        end
        issued++;
        nops = 0;
        repeat (4) begin
            if (NOP_SLOT === 1'h1) nops++;
            @(negedge CORE_CLK);
        end
    endtask

    task automatic hw(input logic [4:0] we, input logic [4:0] v, input logic st, input logic [4:0] exp);
        @(posedge CORE_CLK);
        FLAG_WE  <= we;
        FLAG_VAL <= v;
        Z_STICKY <= st;
        @(posedge CORE_CLK);
        FLAG_WE  <= 5'h00;
        @(negedge CORE_CLK);
        check("FLAGS", FLAGS, exp);
    endtask

    initial begin
        SYS_RST = 1'h1; AVS_ADDRESS = 4'h0; AVS_READ = 1'h0; AVS_WRITE = 1'h0; AVS_WRITEDATA = 32'h0;
        FLAG_WE = 5'h00; FLAG_VAL = 5'h00; Z_STICKY = 1'h0;
        repeat (6) @(posedge CORE_CLK);
        SYS_RST <= 1'h0;
        check("idle ready", {AVS_WAITREQUEST, INSTR_READY, EXEC_VALID}, 3'h6);
        bus(1'h0, `REG_CTRL, 32'h0); check("CTRL", q, 32'h1);
        bus(1'h0, `REG_FLAGS, 32'h0); check("FLAGS reg", q, 32'h0);
        bus(1'h0, `REG_STATE, 32'h0); check("STATE", q, 32'h0);
        bus(1'h1, 4'h6, 32'hFFFFFFFF);
        bus(1'h0, 4'h2, 32'h0); check("unmapped", q, 32'h0);
        for (int i = 0; i < 14; i++) begin
            run(tw[i], tc[i], ts[i], 3'h0);
            check("cycles", EXEC_CYCLES, te[i]);
            check("nop slots", nops, te[i] - 2'h1);
        end
        for (int l = 0; l < 8; l++) begin
            run({`OPC_FILE, 16'hFFFF}, 1'h0, 1'h0, l[2:0]);
            if (l < 7) check("LIT_UNS", LIT_UNS, lu[l]);
            check("LIT_SIG", LIT_SIG, 16'hFFFF);
            check("size", {SIZE, SHADOW, BIT_INDEX_FIELD, DEST_OPERAND}, 11'h01FF);
            check("FILE_ADDR", FILE_ADDR, 13'h1FFF);
            check("OPCODE", OPCODE, `OPC_FILE);
        end
        run({`OPC_FILE, 16'h4FFF}, 1'h0, 1'h0, `LSEL_10);
        check("byte unsigned_ten_bit_literal", {SIZE, LIT_UNS}, {2'h1, 16'h00FF});
        run({`OPC_FILE, 16'h1ABC}, 1'h0, 1'h0, 3'h0);
        check("default dest", {DEST_OPERAND, FILE_ADDR}, {4'h0, 13'h1ABC});
        run({`OPC_MOV_EXT, 16'h356F}, 1'h0, 1'h0, 3'h0);
        check("ext operands", {SOURCE_OPERAND, SRC_MODE, DEST_OPERAND, DST_MODE, BASE_WORK_REG, FORM_ERR},
            {4'hF, 3'h6, 4'hA, 3'h6, 4'h3, 1'h0});
        run({`OPC_MOV, 16'h356F}, 1'h0, 1'h0, 3'h0);
        check("offset refused", FORM_ERR, 1'h1);
        for (int m = 0; m < 8; m++) begin
            run({`OPC_MOV, 9'h000, m[2:0], 4'h5}, 1'h0, 1'h0, 3'h0);
            check("mode", {SRC_MODE, SOURCE_OPERAND, FORM_ERR}, {m[2:0], 4'h5, m > 5});
        end
        run({`OPC_SQR, 16'h000E}, 1'h0, 1'h0, 3'h0);
        check("square reg", DIVIDEND_OR_SQUARE_REG, 4'h6);
        run({`OPC_DIV, 16'h0019}, 1'h0, 1'h0, 3'h0);
        check("div indirect", {DIVIDEND_OR_SQUARE_REG, FORM_ERR}, 5'h13);
        run({`OPC_DIV, 16'h0009}, 1'h0, 1'h0, 3'h0);
        check("div direct", FORM_ERR, 1'h0);
        mcu16_fetch_model_inst.send({`OPC_ABSOLUTE_JUMP_ABS, 16'hABCD}, 1'h0, 1'h0, 3'h0, ok);
        check("absolute_jump word taken", ok, 1'h1);
        run(24'h000055, 1'h0, 1'h0, 3'h0);
        check("absolute_jump", {EXEC_CYCLES, PROGRAM_ADDRESS_LITERAL}, {2'h2, 7'h55, 15'h55E6, 1'h0});
        bus(1'h0, `REG_STATE, 32'h0); check("STATE ok", q, 32'h02);
        mcu16_fetch_model_inst.send({`OPC_CALL_ABS, 16'h0000}, 1'h0, 1'h0, 3'h0, ok);
        check("call word taken", ok, 1'h1);
        run(24'h010000, 1'h0, 1'h0, 3'h0);
        bus(1'h0, `REG_STATE, 32'h0); check("STATE err", q, 32'h12);
        bus(1'h1, `REG_CTRL, 32'h3);
        bus(1'h0, `REG_STATE, 32'h0); check("err cleared", q, 32'h02);
        bus(1'h1, `REG_CTRL, 32'h0);
        @(negedge CORE_CLK);
        check("ready disabled", INSTR_READY, 1'h0);
        bus(1'h0, `REG_CTRL, 32'h0); check("CTRL off", q, 32'h0);
        bus(1'h1, `REG_CTRL, 32'h1);
        bus(1'h0, `REG_COUNT, 32'h0); check("COUNT", q, issued);
        bus(1'h1, `REG_FLAGS, 32'h1F);
        bus(1'h0, `REG_FLAGS, 32'h0); check("FLAGS rw", q, 32'h1F);
        hw(5'h10, 5'h10, 1'h1, 5'h1F);
        hw(5'h10, 5'h00, 1'h1, 5'h0F);
        hw(5'h10, 5'h10, 1'h1, 5'h0F);
        hw(5'h10, 5'h10, 1'h0, 5'h1F);
        hw(5'h0F, 5'h05, 1'h0, 5'h15);
        conclude();
    end
endmodule // mcu16_instr_timing_operands_tb_top
